/* data_buffer_status_defines.svh */
// register map, field positions and reset values of the buffer status block
`ifndef DATA_BUFFER_STATUS_DEFINES_SVH
`define DATA_BUFFER_STATUS_DEFINES_SVH

// ************************************************************
// map
// ************************************************************
`define DBS_NUM_BUF          8
`define DBS_ADDR_W           12
`define DBS_OFF_STATUS_LOW   12'h144
`define DBS_OFF_STATUS_HIGH  12'h148
`define DBS_OFF_CFG_BASE     12'h180
`define DBS_CFG_BLOCK_MASK   12'hfe0
`define DBS_CFG_IDX_LSB      2
`define DBS_CFG_IDX_W        3
`define DBS_OFF_IRQ_STATUS   12'h1a0
`define DBS_OFF_IRQ_MASK     12'h1a4

// ************************************************************
// status lane layout
// ************************************************************
`define DBS_BIT_EMPTY        0
`define DBS_BIT_FULL         1
`define DBS_BIT_CELL         2
`define DBS_BIT_LVL0         3
`define DBS_BIT_LVL1         4
`define DBS_RSVD_W           3
`define DBS_LANE_RST         5'h09
`define DBS_STATUS_RST       32'h0909_0909
`define DBS_RSVD_MASK        32'he0e0_e0e0

// ************************************************************
// per-buffer level configuration word
// ************************************************************
`define DBS_TH0_LSB          0
`define DBS_TH1_LSB          16
`define DBS_DIR0_BIT         30
`define DBS_DIR1_BIT         31
`define DBS_TH0_RST          16'h0001
`define DBS_TH1_RST          16'h0010
`define DBS_IRQ_W            16

`endif

/* dbs_pkg.sv */
// shared types of the buffer status block
package dbs_pkg;
  typedef enum logic {DIR_BELOW, DIR_ABOVE} level_dir_e;
  typedef logic [4:0] lane_t;
endpackage

/* lane_if.sv */
// per-buffer carrier between the status top and one flag unit
interface lane_if #(
  parameter int CNT_W = 10
) ();
  logic [CNT_W-1:0]        level;
  logic [CNT_W-1:0]        th0;
  logic [CNT_W-1:0]        th1;
  dbs_pkg::level_dir_e     dir0;
  dbs_pkg::level_dir_e     dir1;
  logic                    cellAvail;
  dbs_pkg::lane_t          flags;
  logic                    rise0;
  logic                    rise1;

  modport unit (
    input  level, th0, th1, dir0, dir1, cellAvail,
    output flags, rise0, rise1
  );
  modport owner (
    output level, th0, th1, dir0, dir1, cellAvail,
    input  flags, rise0, rise1
  );
endinterface

/* buffer_lane_flags.sv */
// live status flags of one data buffer
`include "data_buffer_status_defines.svh"

module buffer_lane_flags #(
  parameter int CNT_W = 10,
  parameter int DEPTH = 512
) (
  input wire logic clk,
  input wire logic rstN,
  lane_if.unit     lane
);

  dbs_pkg::lane_t flags_q;
  dbs_pkg::lane_t flags_d;

  // strict compare: a level equal to the threshold has not crossed it
  function automatic logic crossed(input logic [CNT_W-1:0] lvl,
                                   input logic [CNT_W-1:0] thr,
                                   input dbs_pkg::level_dir_e dir);
    return (dir == dbs_pkg::DIR_ABOVE) ? (lvl > thr) : (lvl < thr);
  endfunction

  always_comb begin
    flags_d = '0;
    flags_d[`DBS_BIT_EMPTY] = (lane.level == '0);
    flags_d[`DBS_BIT_FULL]  = (lane.level >= CNT_W'(DEPTH));
    flags_d[`DBS_BIT_CELL]  = lane.cellAvail;
    flags_d[`DBS_BIT_LVL0]  = crossed(lane.level, lane.th0, lane.dir0);
    flags_d[`DBS_BIT_LVL1]  = crossed(lane.level, lane.th1, lane.dir1);
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flags_q <= `DBS_LANE_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign lane.flags = flags_q;
  assign lane.rise0 = flags_d[`DBS_BIT_LVL0] & ~flags_q[`DBS_BIT_LVL0];
  assign lane.rise1 = flags_d[`DBS_BIT_LVL1] & ~flags_q[`DBS_BIT_LVL1];

  AST_EMPTY_TRACKS: assert property (@(posedge clk) disable iff (!rstN)
    1'b1 |=> lane.flags[`DBS_BIT_EMPTY] == ($past(lane.level) == '0))
    else $error("empty flag does not follow buffer level");
  AST_FULL_TRACKS: assert property (@(posedge clk) disable iff (!rstN)
    lane.level >= CNT_W'(DEPTH) |=> lane.flags[`DBS_BIT_FULL])
    else $error("full flag missing at full level");
  AST_LVL0_ABOVE: assert property (@(posedge clk) disable iff (!rstN)
    lane.dir0 == dbs_pkg::DIR_ABOVE && lane.level > lane.th0 |=> lane.flags[`DBS_BIT_LVL0])
    else $error("first level flag missed rising crossing");
  AST_LVL0_BELOW: assert property (@(posedge clk) disable iff (!rstN)
    lane.dir0 == dbs_pkg::DIR_BELOW && lane.level >= lane.th0 |=> !lane.flags[`DBS_BIT_LVL0])
    else $error("first level flag set without falling crossing");
  AST_LVL1_DIR: assert property (@(posedge clk) disable iff (!rstN)
    ##1 lane.flags[`DBS_BIT_LVL1] == (($past(lane.dir1) == dbs_pkg::DIR_ABOVE) ?
        ($past(lane.level) > $past(lane.th1)) : ($past(lane.level) < $past(lane.th1))))
    else $error("second level flag disagrees with its crossing");

endmodule

/* irq_sticky.sv */
// sticky event status with mask and one level interrupt
module irq_sticky #(
  parameter int W = 16
) (
  input wire logic         clk,
  input wire logic         rstN,
  input wire logic [W-1:0] evt,
  input wire logic         wrStatus,
  input wire logic         wrMask,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0]     status,
  output logic [W-1:0]     mask,
  output logic             irq
);

  logic [W-1:0] status_q;
  logic [W-1:0] mask_q;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(wrStatus ? wdata : '0)) | evt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mask_q <= '0;
    end else if (wrMask) begin
      mask_q <= wdata;
    end
  end

  assign status = status_q;
  assign mask   = mask_q;
  assign irq    = |(status_q & mask_q);

  AST_IRQ_SET_WINS: assert property (@(posedge clk) disable iff (!rstN)
    evt[0] |=> status[0])
    else $error("event lost in sticky status");

endmodule

/* data_buffer_status_flags.sv */
// buffer status top: flag units, level configuration, interrupts and apb slave
`include "data_buffer_status_defines.svh"

module data_buffer_status_flags #(
  parameter int CNT_W  = 10,
  parameter int DEPTH  = 512,
  parameter int CELL_W = 4
) (
  input wire logic                                 clk,
  input wire logic                                 rst_n,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [`DBS_ADDR_W-1:0]               paddr,
  input wire logic [31:0]                          pwdata,
  output logic                                     pready,
  output logic [31:0]                              prdata,
  output logic                                     pslverr,
  input wire logic [`DBS_NUM_BUF-1:0][CNT_W-1:0]   bufLevel,
  input wire logic [`DBS_NUM_BUF-1:0]              cellConfirm,
  input wire logic [`DBS_NUM_BUF-1:0]              cellTaken,
  output logic [`DBS_NUM_BUF-1:0]                  bufWriteAllow,
  output logic [`DBS_NUM_BUF-1:0]                  bufReadAllow,
  output logic                                     irq
);

  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rstSync_q;
  logic       rstN;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ************************************************************
  // declarations
  // ************************************************************
  logic [CNT_W-1:0]             th0_q   [`DBS_NUM_BUF];
  logic [CNT_W-1:0]             th1_q   [`DBS_NUM_BUF];
  dbs_pkg::level_dir_e          dir0_q  [`DBS_NUM_BUF];
  dbs_pkg::level_dir_e          dir1_q  [`DBS_NUM_BUF];
  logic [CELL_W-1:0]            cells_q [`DBS_NUM_BUF];
  dbs_pkg::lane_t               laneFlags [`DBS_NUM_BUF];
  logic [`DBS_NUM_BUF-1:0]      rise0;
  logic [`DBS_NUM_BUF-1:0]      rise1;
  logic [31:0]                  statusLow;
  logic [31:0]                  statusHigh;
  logic [31:0]                  rdWord;
  logic                         rdErr;
  logic                         cfgHit;
  logic [`DBS_CFG_IDX_W-1:0]    cfgIdx;
  logic                         setupPhase;
  logic                         wrEn;
  logic [`DBS_IRQ_W-1:0]        irqStatus;
  logic [`DBS_IRQ_W-1:0]        irqMask;

  // ************************************************************
  // flag units, one per buffer
  // ************************************************************
  lane_if #(.CNT_W(CNT_W)) lanes [`DBS_NUM_BUF] ();

  for (genvar g = 0; g < `DBS_NUM_BUF; g++) begin : gLane
    assign lanes[g].level     = bufLevel[g];
    assign lanes[g].th0       = th0_q[g];
    assign lanes[g].th1       = th1_q[g];
    assign lanes[g].dir0      = dir0_q[g];
    assign lanes[g].dir1      = dir1_q[g];
    assign lanes[g].cellAvail = (cells_q[g] != '0);
    assign laneFlags[g]       = lanes[g].flags;
    assign rise0[g]           = lanes[g].rise0;
    assign rise1[g]           = lanes[g].rise1;
    // the data path uses these to keep itself off a full or empty buffer
    assign bufWriteAllow[g]   = ~laneFlags[g][`DBS_BIT_FULL];
    assign bufReadAllow[g]    = ~laneFlags[g][`DBS_BIT_EMPTY];

    buffer_lane_flags #(
      .CNT_W (CNT_W),
      .DEPTH (DEPTH)
    ) uFlags (
      .clk  (clk),
      .rstN (rstN),
      .lane (lanes[g].unit)
    );
  end

  // ************************************************************
  // confirmed cells waiting in each buffer
  // ************************************************************
  // saturates rather than wraps so a burst of confirms never hides a cell
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < `DBS_NUM_BUF; i++) begin
        cells_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `DBS_NUM_BUF; i++) begin
        if (cellConfirm[i] && !cellTaken[i] && cells_q[i] != '1) begin
          cells_q[i] <= cells_q[i] + CELL_W'(1);
        end else if (!cellConfirm[i] && cellTaken[i] && cells_q[i] != '0) begin
          cells_q[i] <= cells_q[i] - CELL_W'(1);
        end
      end
    end
  end

  // ************************************************************
  // status words
  // ************************************************************
  function automatic logic [31:0] packWord(input dbs_pkg::lane_t l0,
                                           input dbs_pkg::lane_t l1,
                                           input dbs_pkg::lane_t l2,
                                           input dbs_pkg::lane_t l3);
    return {{`DBS_RSVD_W{1'b0}}, l3, {`DBS_RSVD_W{1'b0}}, l2,
            {`DBS_RSVD_W{1'b0}}, l1, {`DBS_RSVD_W{1'b0}}, l0};
  endfunction

  assign statusLow  = packWord(laneFlags[0], laneFlags[1],
                               laneFlags[2], laneFlags[3]);
  assign statusHigh = packWord(laneFlags[4], laneFlags[5],
                               laneFlags[6], laneFlags[7]);

  function automatic logic [31:0] cfgWord(input logic [CNT_W-1:0] t0,
                                          input logic [CNT_W-1:0] t1,
                                          input dbs_pkg::level_dir_e d0,
                                          input dbs_pkg::level_dir_e d1);
    logic [31:0] w;
    w = '0;
    w[`DBS_TH0_LSB +: CNT_W] = t0;
    w[`DBS_TH1_LSB +: CNT_W] = t1;
    w[`DBS_DIR0_BIT] = (d0 == dbs_pkg::DIR_ABOVE);
    w[`DBS_DIR1_BIT] = (d1 == dbs_pkg::DIR_ABOVE);
    return w;
  endfunction

  // ************************************************************
  // apb decode
  // ************************************************************
  assign cfgHit     = (paddr & `DBS_CFG_BLOCK_MASK) == `DBS_OFF_CFG_BASE;
  assign cfgIdx     = paddr[`DBS_CFG_IDX_LSB +: `DBS_CFG_IDX_W];
  assign setupPhase = psel & ~penable;
  // zero wait states: every access completes in its first access cycle
  assign pready     = psel & penable;
  // the error answer was settled in setup, so a refused write stores nothing
  assign wrEn       = psel & penable & pwrite & ~pslverr;

  always_comb begin
    rdWord = '0;
    rdErr  = 1'b0;
    case (paddr)
      `DBS_OFF_STATUS_LOW: begin
        rdWord = statusLow;
      end
      `DBS_OFF_STATUS_HIGH: begin
        rdWord = statusHigh;
      end
      `DBS_OFF_IRQ_STATUS: begin
        rdWord = 32'(irqStatus);
      end
      `DBS_OFF_IRQ_MASK: begin
        rdWord = 32'(irqMask);
      end
      default: begin
        if (cfgHit && paddr[1:0] == 2'h0) begin
          rdWord = cfgWord(th0_q[cfgIdx], th1_q[cfgIdx], dir0_q[cfgIdx], dir1_q[cfgIdx]);
        end else begin
          rdErr = 1'b1;
        end
      end
    endcase
  end

  // read data is caught in setup; reading status changes nothing
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? 32'h0 : rdWord;
      pslverr <= rdErr;
    end
  end

  // ************************************************************
  // level configuration registers
  // ************************************************************
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < `DBS_NUM_BUF; i++) begin
        th0_q[i]  <= CNT_W'(`DBS_TH0_RST);
        th1_q[i]  <= CNT_W'(`DBS_TH1_RST);
        dir0_q[i] <= dbs_pkg::DIR_BELOW;
        dir1_q[i] <= dbs_pkg::DIR_ABOVE;
      end
    end else if (wrEn && cfgHit) begin
      th0_q[cfgIdx]  <= pwdata[`DBS_TH0_LSB +: CNT_W];
      th1_q[cfgIdx]  <= pwdata[`DBS_TH1_LSB +: CNT_W];
      dir0_q[cfgIdx] <= dbs_pkg::level_dir_e'(pwdata[`DBS_DIR0_BIT]);
      dir1_q[cfgIdx] <= dbs_pkg::level_dir_e'(pwdata[`DBS_DIR1_BIT]);
    end
  end

  // ************************************************************
  // interrupts on level flag rising edges
  // ************************************************************
  irq_sticky #(
    .W (`DBS_IRQ_W)
  ) uIrq (
    .clk      (clk),
    .rstN     (rstN),
    .evt      ({rise1, rise0}),
    .wrStatus (wrEn && paddr == `DBS_OFF_IRQ_STATUS),
    .wrMask   (wrEn && paddr == `DBS_OFF_IRQ_MASK),
    .wdata    (pwdata[`DBS_IRQ_W-1:0]),
    .status   (irqStatus),
    .mask     (irqMask),
    .irq      (irq)
  );

  // ************************************************************
  // checks
  // ************************************************************
  AST_RESET_LANES: assert property (@(posedge clk) disable iff (!rstN)
    $rose(rstN) |-> statusLow == `DBS_STATUS_RST && statusHigh == `DBS_STATUS_RST)
    else $error("status words wrong after reset");

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && (paddr == `DBS_OFF_STATUS_LOW || paddr == `DBS_OFF_STATUS_HIGH)
    |-> (prdata & `DBS_RSVD_MASK) == 32'h0)
    else $error("reserved status bits read non-zero");

  AST_LOW_LANE0: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_LOW
    |-> prdata[4:0] == $past(laneFlags[0]))
    else $error("buffer zero lane misplaced");

  AST_LOW_LANE3: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_LOW
    |-> prdata[12:8] == $past(laneFlags[1]) && prdata[28:24] == $past(laneFlags[3]))
    else $error("buffers one to three misplaced");

  AST_HIGH_LANES: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_HIGH
    |-> prdata[4:0] == $past(laneFlags[4]) && prdata[28:24] == $past(laneFlags[7]))
    else $error("buffers four to seven misplaced");

  AST_LANE_BITS: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_LOW
    |-> prdata[`DBS_BIT_FULL] == !$past(bufWriteAllow[0])
        && prdata[`DBS_BIT_EMPTY] == !$past(bufReadAllow[0]))
    else $error("lane bit order wrong");

  AST_STATUS_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rstN)
    pready && pwrite && paddr == `DBS_OFF_STATUS_LOW
    |=> $stable(th0_q[0]) && $stable(irqMask) && ($past(irqStatus) & ~irqStatus) == '0)
    else $error("write to status word changed state");

  AST_CELL_READY: assert property (@(posedge clk) disable iff (!rstN)
    cellConfirm[2] && !cellTaken[2] |-> ##2 laneFlags[2][`DBS_BIT_CELL])
    else $error("confirmed cell not reported");

  AST_FULL_BLOCKS: assert property (@(posedge clk) disable iff (!rstN)
    bufLevel[0] >= CNT_W'(DEPTH) |-> ##1 !bufWriteAllow[0])
    else $error("write allowed into full buffer");

  AST_EMPTY_BLOCKS: assert property (@(posedge clk) disable iff (!rstN)
    bufLevel[1] == '0 |-> ##1 !bufReadAllow[1])
    else $error("read allowed from empty buffer");

  AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (!rstN)
    setupPhase && rdErr |=> pslverr)
    else $error("unmapped address not refused");

  AST_LOW_LANE2: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_LOW
    |-> prdata[20:16] == $past(laneFlags[2]))
    else $error("buffer two lane misplaced");

  AST_HIGH_LANE5: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_HIGH
    |-> prdata[12:8] == $past(laneFlags[5]) && prdata[20:16] == $past(laneFlags[6]))
    else $error("buffers five and six misplaced");

  AST_RESET_ALLOW: assert property (@(posedge clk) disable iff (!rstN)
    $rose(rstN) |-> &bufWriteAllow && bufReadAllow == '0)
    else $error("buffer gates wrong after reset");

  AST_CELL_CLEARS: assert property (@(posedge clk) disable iff (!rstN)
    cells_q[2] == '0 |-> ##1 !laneFlags[2][`DBS_BIT_CELL])
    else $error("cell-ready shown with no confirmed cell");

  AST_DATA_OPENS: assert property (@(posedge clk) disable iff (!rstN)
    bufLevel[0] != '0 |-> ##1 bufReadAllow[0])
    else $error("read blocked on a buffer holding data");

  AST_CFG_TH0: assert property (@(posedge clk) disable iff (!rstN)
    wrEn && cfgHit && cfgIdx == '0 |=> th0_q[0] == $past(pwdata[`DBS_TH0_LSB +: CNT_W]))
    else $error("first threshold write lost");

  AST_CFG_DIR1: assert property (@(posedge clk) disable iff (!rstN)
    wrEn && cfgHit && cfgIdx == '0
    |=> dir1_q[0] == dbs_pkg::level_dir_e'($past(pwdata[`DBS_DIR1_BIT])))
    else $error("second direction write lost");

  // a mask write in the same cycle may legally hide the event, so it is left out
  AST_IRQ_ON_RISE: assert property (@(posedge clk) disable iff (!rstN)
    rise1[1] && irqMask[`DBS_NUM_BUF + 1] && !wrEn |=> irq)
    else $error("unmasked level event raised no interrupt");

  AST_ERR_READ_ZERO: assert property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");

  COV_READ_LOW: cover property (@(posedge clk) disable iff (!rstN)
    pready && !pwrite && paddr == `DBS_OFF_STATUS_LOW);
  COV_LVL0_RISE: cover property (@(posedge clk) disable iff (!rstN)
    rise0[0] ##1 irq);
  COV_FULL: cover property (@(posedge clk) disable iff (!rstN)
    !bufWriteAllow[7]);
  COV_CELL: cover property (@(posedge clk) disable iff (!rstN)
    cellConfirm[2] ##2 laneFlags[2][`DBS_BIT_CELL]);
  COV_UNMAPPED: cover property (@(posedge clk) disable iff (!rstN)
    setupPhase && rdErr);

endmodule

/* host_apb_model.sv */
// apb host model issuing register cycles to the buffer status block
`include "data_buffer_status_defines.svh"

module host_apb_model (
  input wire logic                   clk,
  output logic                       psel,
  output logic                       penable,
  output logic                       pwrite,
  output logic [`DBS_ADDR_W-1:0]     paddr,
  output logic [31:0]                pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // ************************************************************
  // one transfer: setup, access held until pready is sampled high
  // ************************************************************
  task automatic xfer(input logic wr, input logic [`DBS_ADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic hung);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    hung = (n >= 50);
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse so a stale value is never mistaken for a live one
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

/* data_buffer_status_flags_tb_top.sv */
// self-checking testbench of the buffer status block
`include "data_buffer_status_defines.svh"
`define CHECK_EQ(g, e) begin comparisons++; if ((g) !== (e)) begin errCount++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module data_buffer_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CW = 10;
  localparam int DP = 512;

  logic                  clk;
  logic                  rst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  logic [7:0][CW-1:0]    bufLevel;
  logic [7:0]            cellConfirm;
  logic [7:0]            cellTaken;
  logic [7:0]            bufWriteAllow;
  logic [7:0]            bufReadAllow;
  logic                  irq;
  int                    errCount;
  int                    comparisons;
  int                    lvl [8];
  int                    cnt [8];
  int                    t0 [8];
  int                    t1 [8];
  bit                    a0 [8];
  bit                    a1 [8];

  data_buffer_status_flags #(.CNT_W(CW), .DEPTH(DP), .CELL_W(4)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bufLevel(bufLevel), .cellConfirm(cellConfirm), .cellTaken(cellTaken),
    .bufWriteAllow(bufWriteAllow), .bufReadAllow(bufReadAllow), .irq(irq));

  host_apb_model host_u (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic completeRun();
    $display("mismatches=%0d comparisons=%0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ************************************************************
  // bus access and expectations
  // ************************************************************
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        err;
    logic        hung;
    host_u.xfer(wr, a, wd, rd, err, hung);
    if (hung !== 1'b0) begin
      errCount++;
      completeRun();
    end else if (wr) begin
      `CHECK_EQ(err, expErr)
    end else begin
      `CHECK_EQ({err, rd}, {expErr, exp})
    end
  endtask

  function automatic logic [7:0] laneExp(int i);
    laneExp = {3'h0, a1[i] ? lvl[i] > t1[i] : lvl[i] < t1[i], a0[i] ? lvl[i] > t0[i] : lvl[i] < t0[i],
               cnt[i] > 0, lvl[i] >= DP, lvl[i] == 0};
  endfunction

  function automatic logic [31:0] wordExp(int base);
    for (int i = 0; i < 4; i++) wordExp[8*i +: 8] = laneExp(base + i);
  endfunction

  task automatic checkStatus();
    acc(1'b0, `DBS_OFF_STATUS_LOW, 32'h0, wordExp(0), 1'b0);
    acc(1'b0, `DBS_OFF_STATUS_HIGH, 32'h0, wordExp(4), 1'b0);
  endtask

  task automatic setLvl(input int n, input int v);
    @(posedge clk);
    bufLevel[n] <= CW'(v);
    lvl[n] = v;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(input bit tk, input int n, input int k);
    repeat (k) begin
      @(posedge clk);
      if (tk) cellTaken <= 8'h01 << n;
      else cellConfirm <= 8'h01 << n;
      cnt[n] += tk ? -1 : 1;
    end
    @(posedge clk);
    cellTaken <= 8'h00;
    cellConfirm <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic testReset();
    acc(1'b0, `DBS_OFF_STATUS_LOW, 32'h0, 32'h0909_0909, 1'b0);
    acc(1'b0, `DBS_OFF_STATUS_HIGH, 32'h0, 32'h0909_0909, 1'b0);
    `CHECK_EQ({irq, bufReadAllow, bufWriteAllow}, 17'h000ff)
  endtask

  task automatic testWriteIgnored();
    acc(1'b1, `DBS_OFF_STATUS_LOW, 32'hffff_ffff, 32'h0, 1'b0);
    acc(1'b1, `DBS_OFF_STATUS_HIGH, 32'hffff_ffff, 32'h0, 1'b0);
    checkStatus();
  endtask

  task automatic testLanes();
    for (int n = 0; n < 8; n++) begin
      setLvl(n, DP);
      checkStatus();
      `CHECK_EQ({bufWriteAllow, bufReadAllow}, {~(8'h01 << n), 8'h01 << n})
      setLvl(n, 0);
    end
  endtask

  task automatic testBounds();
    int seq [6] = '{1, 16, 17, 5, 6, 8};
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        // flip both crossings so each direction is seen at its strict edge
        acc(1'b1, `DBS_OFF_CFG_BASE, 32'h4008_0005, 32'h0, 1'b0);
        acc(1'b0, `DBS_OFF_CFG_BASE, 32'h0, 32'h4008_0005, 1'b0);
        t0[0] = 5;
        t1[0] = 8;
        a0[0] = 1'b1;
        a1[0] = 1'b0;
      end
      setLvl(0, seq[i]);
      checkStatus();
    end
    acc(1'b1, `DBS_OFF_CFG_BASE, 32'h8010_0001, 32'h0, 1'b0);
    acc(1'b0, `DBS_OFF_CFG_BASE, 32'h0, 32'h8010_0001, 1'b0);
    t0[0] = 1;
    t1[0] = 16;
    a0[0] = 1'b0;
    a1[0] = 1'b1;
    setLvl(0, 0);
    checkStatus();
  endtask

  task automatic testCell();
    pulse(1'b0, 2, 2);
    checkStatus();
    checkStatus();
    pulse(1'b1, 2, 1);
    checkStatus();
    pulse(1'b1, 2, 1);
    checkStatus();
  endtask

  task automatic testIrq();
    acc(1'b1, `DBS_OFF_IRQ_STATUS, 32'h0000_ffff, 32'h0, 1'b0);
    acc(1'b1, `DBS_OFF_IRQ_MASK, 32'h0000_0200, 32'h0, 1'b0);
    acc(1'b0, `DBS_OFF_IRQ_MASK, 32'h0, 32'h0000_0200, 1'b0);
    setLvl(3, 20);
    `CHECK_EQ(irq, 1'b0)
    setLvl(1, 20);
    `CHECK_EQ(irq, 1'b1)
    acc(1'b0, `DBS_OFF_IRQ_STATUS, 32'h0, 32'h0000_0a00, 1'b0);
    acc(1'b1, `DBS_OFF_IRQ_STATUS, 32'h0000_0200, 32'h0, 1'b0);
    // the clear lands on the access edge itself, so irq is looked at one edge later
    @(posedge clk);
    `CHECK_EQ(irq, 1'b0)
    acc(1'b0, `DBS_OFF_IRQ_STATUS, 32'h0, 32'h0000_0800, 1'b0);
    checkStatus();
  endtask

  task automatic testUnmapped();
    acc(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 12'h146, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 12'h182, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 12'h100, 32'h1234_5678, 32'h0, 1'b1);
    checkStatus();
  endtask

  initial begin
    rst_n = 1'b0;
    bufLevel = '0;
    cellConfirm = 8'h00;
    cellTaken = 8'h00;
    errCount = 0;
    comparisons = 0;
    for (int i = 0; i < 8; i++) begin
      lvl[i] = 0;
      cnt[i] = 0;
      t0[i] = 1;
      t1[i] = 16;
      a0[i] = 1'b0;
      a1[i] = 1'b1;
    end
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    testReset();
    testWriteIgnored();
    testLanes();
    testBounds();
    testCell();
    testIrq();
    testUnmapped();
    completeRun();
  end
endmodule
